// ---- rtl/sso_pkg.sv ----
package sso_pkg;

  // Monitored safety functions, one bit each in every function vector
  localparam int SSO_NUM_FUNC = 14;
  localparam int SSO_IDX_TORQUE_OFF = 0;
  localparam int SSO_IDX_SINGLE_CHANNEL = 1;
  localparam int SSO_IDX_BRAKE = 2;
  localparam int SSO_IDX_OP_STOP = 3;
  localparam int SSO_IDX_STOP_ONE = 4;
  localparam int SSO_IDX_STOP_TWO = 5;
  localparam int SSO_IDX_SPEED_ONE = 6;
  localparam int SSO_IDX_SPEED_TWO = 7;
  localparam int SSO_IDX_SPEED_THREE = 8;
  localparam int SSO_IDX_SPEED_FOUR = 9;
  localparam int SSO_IDX_INCREMENT = 10;
  localparam int SSO_IDX_DIR_POS = 11;
  localparam int SSO_IDX_DIR_NEG = 12;
  localparam int SSO_IDX_POS_LIMIT = 13;

  // Register map, byte addresses of aligned 32-bit words
  localparam logic [11:0] SSO_ADDR_CTRL = 12'h000;
  localparam logic [11:0] SSO_ADDR_STATUS = 12'h004;
  localparam logic [11:0] SSO_ADDR_POSITION = 12'h008;
  localparam logic [11:0] SSO_ADDR_FAULTS = 12'h00C;

  // Field positions and reset values
  localparam int SSO_CTRL_ACTIVATE_BIT = 0;
  localparam logic SSO_ACTIVATE_RESET = 1'b0;
  localparam logic [31:0] SSO_WORD_ZERO = 32'h0000_0000;
  localparam int SSO_STATUS_WIDTH = 18;

  // Per-function state from the module's monitoring logic
  typedef struct packed {
    logic [SSO_NUM_FUNC-1:0] request;
    logic [SSO_NUM_FUNC-1:0] active;
    logic [SSO_NUM_FUNC-1:0] safe;
    logic [SSO_NUM_FUNC-1:0] error;
  } sso_func_t;

  // Axis-wide state: homing, encoder, monitors, module error
  typedef struct packed {
    logic module_error;
    logic homed;
    logic encoder_fault;
    logic max_position_monitor;
    logic ramp_monitor;
    logic [31:0] position;
  } sso_axis_t;

  // Status outputs towards the safe application
  typedef struct packed {
    logic ready;
    logic torque_off_safe_flag;
    logic single_channel_torque_off_flag;
    logic brake_control_safe_flag;
    logic operating_stop_safe_flag;
    logic stop_one_safe_flag;
    logic stop_two_safe_flag;
    logic speed_limit_one_flag;
    logic speed_limit_two_flag;
    logic speed_limit_three_flag;
    logic speed_limit_four_flag;
    logic increment_limit_safe_flag;
    logic direction_positive_safe_flag;
    logic direction_negative_safe_flag;
    logic position_limit_safe_flag;
    logic max_position_safe_flag;
    logic homed_position_valid;
    logic ramp_monitor_flag;
  } sso_status_t;

  localparam sso_status_t SSO_STATUS_RESET = '0;

endpackage : sso_pkg

// ---- rtl/sso_status_outputs.sv ----
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
// Operation
// - Activated: ready high, flags follow functions
// - Deactivated: ready low, all flags low
// - Torque-off flag: requested, active, safe, no error
// - Single-channel torque-off flag likewise, else low
// - Brake control flag likewise, else low
// - Operating stop flag likewise, else low
// - Stop one flag only after safe state
// - Stop two flag only after safe state
// - Four speed limit flags, each separate
// - Staged flags stay low until safe
// - Increment limit flag likewise, else low
// - Positive direction flag likewise, else low
// - Negative direction flag likewise, else low
// - Position limit flag likewise, else low
// - Max position flag needs homing, monitoring, no error
// - Position valid only after homing completed
// - Position valid cleared on faults or inactive
// - Ramp monitor flag follows monitor, else low
module sso_status_outputs
  import sso_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire sso_func_t FUNC_STATE,
  input wire sso_axis_t AXIS_STATE,
  output sso_status_t STATUS,
  output logic [31:0] SAFE_POSITION_VALUE
);

  logic activate;
  logic setup;
  logic access_done;
  logic mapped;
  logic any_error;
  logic position_ok;
  logic [SSO_NUM_FUNC-1:0] next_flags;
  sso_status_t next_status;
  logic [31:0] next_rdata;

  // Bus phases; a write lands only at the access edge with pready high
  assign setup = PSEL && !PENABLE;
  assign access_done = PSEL && PENABLE && PREADY;
  assign any_error = AXIS_STATE.module_error;

  // Address decode for the error answer; read data decodes PADDR in its own case
  always_comb
  begin
    unique case (PADDR)
      SSO_ADDR_CTRL, SSO_ADDR_STATUS, SSO_ADDR_POSITION, SSO_ADDR_FAULTS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // One-cycle answer: pready raised for the first access cycle only
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PREADY <= 1'b0;
    end
    else
    begin
      PREADY <= setup;
    end
  end

  // Unmapped addresses answer with an error and no effect
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PSLVERR <= 1'b0;
    end
    else
    begin
      PSLVERR <= setup && !mapped;
    end
  end

  // Activation bit; software is the only source of activate
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      activate <= SSO_ACTIVATE_RESET;
    end
    else if (access_done && PWRITE && PADDR == SSO_ADDR_CTRL)
    begin
      activate <= PWDATA[SSO_CTRL_ACTIVATE_BIT];
    end
  end

  // Read data, captured in the setup cycle so it stands for the access
  always_comb
  begin
    next_rdata = SSO_WORD_ZERO;
    unique case (PADDR)
      SSO_ADDR_CTRL: next_rdata[SSO_CTRL_ACTIVATE_BIT] = activate;
      SSO_ADDR_STATUS: next_rdata[SSO_STATUS_WIDTH-1:0] = STATUS;
      SSO_ADDR_POSITION: next_rdata = SAFE_POSITION_VALUE;
      SSO_ADDR_FAULTS: next_rdata[SSO_NUM_FUNC-1:0] = FUNC_STATE.error;
      default: next_rdata = SSO_WORD_ZERO;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PRDATA <= SSO_WORD_ZERO;
    end
    else if (setup && !PWRITE)
    begin
      PRDATA <= next_rdata;
    end
  end

  // Every function flag: requested, active, safe, no error of its own, no module error.
  // Staged functions report active only once their safe state is reached,
  // so the same term keeps them low during the stop or speed transition.
  genvar i;
  generate
    for (i = 0; i < SSO_NUM_FUNC; i++)
    begin : g_flag
      assign next_flags[i] = activate && FUNC_STATE.request[i] && FUNC_STATE.active[i]
        && FUNC_STATE.safe[i] && !FUNC_STATE.error[i] && !any_error;
    end
  endgenerate

  // Position validity gates both the flag and the value handed out
  assign position_ok = activate && AXIS_STATE.homed && !AXIS_STATE.encoder_fault
    && !any_error;

  // Map the vector onto named outputs; inactive block forces all low
  always_comb
  begin
    next_status = SSO_STATUS_RESET;
    if (activate)
    begin
      next_status.ready = 1'b1;
      next_status.torque_off_safe_flag = next_flags[SSO_IDX_TORQUE_OFF];
      next_status.single_channel_torque_off_flag = next_flags[SSO_IDX_SINGLE_CHANNEL];
      next_status.brake_control_safe_flag = next_flags[SSO_IDX_BRAKE];
      next_status.operating_stop_safe_flag = next_flags[SSO_IDX_OP_STOP];
      next_status.stop_one_safe_flag = next_flags[SSO_IDX_STOP_ONE];
      next_status.stop_two_safe_flag = next_flags[SSO_IDX_STOP_TWO];
      next_status.speed_limit_one_flag = next_flags[SSO_IDX_SPEED_ONE];
      next_status.speed_limit_two_flag = next_flags[SSO_IDX_SPEED_TWO];
      next_status.speed_limit_three_flag = next_flags[SSO_IDX_SPEED_THREE];
      next_status.speed_limit_four_flag = next_flags[SSO_IDX_SPEED_FOUR];
      next_status.increment_limit_safe_flag = next_flags[SSO_IDX_INCREMENT];
      next_status.direction_positive_safe_flag = next_flags[SSO_IDX_DIR_POS];
      next_status.direction_negative_safe_flag = next_flags[SSO_IDX_DIR_NEG];
      next_status.position_limit_safe_flag = next_flags[SSO_IDX_POS_LIMIT];
      next_status.max_position_safe_flag = AXIS_STATE.homed
        && AXIS_STATE.max_position_monitor && !any_error;
      next_status.homed_position_valid = position_ok;
      next_status.ramp_monitor_flag = AXIS_STATE.ramp_monitor && !any_error;
    end
  end

  // Status register; a deactivated block shows all false next edge
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      STATUS <= SSO_STATUS_RESET;
    end
    else
    begin
      STATUS <= next_status;
    end
  end

  // Position reads zero while invalid, so a careless consumer sees no stale value
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      SAFE_POSITION_VALUE <= SSO_WORD_ZERO;
    end
    else
    begin
      SAFE_POSITION_VALUE <= position_ok ? AXIS_STATE.position : SSO_WORD_ZERO;
    end
  end

endmodule : sso_status_outputs

// ---- verification/sso_props.sv ----
`timescale 1ns/1ps
// Watches the status stage from its ports only
module sso_props
  import sso_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire sso_func_t FUNC_STATE,
  input wire sso_axis_t AXIS_STATE,
  input wire sso_status_t STATUS,
  input wire logic [31:0] SAFE_POSITION_VALUE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // Ready lags activate by one edge, so it gates the sampled inputs
  inactive_clear_a: assert property (!STATUS.ready |-> STATUS[16:0] == 17'h0_0000)
    else $error("flag set while inactive");
  // Flag of function i sits at bit 16-i, right below ready
  for (genvar i = 0; i < SSO_NUM_FUNC; i++)
  begin : g_flag
    func_flag_a: assert property (STATUS[16-i] == (STATUS.ready && $past(FUNC_STATE.request[i]
      && FUNC_STATE.active[i] && FUNC_STATE.safe[i] && !FUNC_STATE.error[i]
      && !AXIS_STATE.module_error))) else $error("function flag wrong");
  end
  max_pos_a: assert property (STATUS.max_position_safe_flag == (STATUS.ready && $past(
    AXIS_STATE.homed && AXIS_STATE.max_position_monitor && !AXIS_STATE.module_error)))
    else $error("max position flag wrong");
  pos_valid_a: assert property (STATUS.homed_position_valid == (STATUS.ready && $past(
    AXIS_STATE.homed && !AXIS_STATE.encoder_fault && !AXIS_STATE.module_error)))
    else $error("position valid wrong");
  ramp_flag_a: assert property (STATUS.ramp_monitor_flag == (STATUS.ready
    && $past(AXIS_STATE.ramp_monitor && !AXIS_STATE.module_error))) else $error("ramp flag wrong");
  pos_value_a: assert property (SAFE_POSITION_VALUE == (STATUS.homed_position_valid
    ? $past(AXIS_STATE.position) : 32'h0000_0000)) else $error("position value wrong");
  error_clear_a: assert property ($past(AXIS_STATE.module_error) |-> !(|STATUS[16:0]))
    else $error("flag survives module error");
  apb_pulse_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("ready pulse wrong");
  slverr_ready_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  cover property ($rose(STATUS.ready));
  cover property ($rose(STATUS.homed_position_valid));
  cover property (PSLVERR);
endmodule : sso_props

bind sso_status_outputs sso_props u_props (.CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .FUNC_STATE(FUNC_STATE),
  .AXIS_STATE(AXIS_STATE), .STATUS(STATUS), .SAFE_POSITION_VALUE(SAFE_POSITION_VALUE));

// ---- verification/sso_app_model.sv ----
`timescale 1ns/1ps
// Safe application side that consumes the status outputs
module sso_app_model
  import sso_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire sso_status_t status,
  input wire logic [31:0] position,
  output logic [31:0] used_pos,
  output logic safe_view
);
  // Position is taken only while valid, so a stale value never leaks in
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      used_pos <= 32'h0000_0000;
    else
      used_pos <= status.homed_position_valid ? position : 32'h0000_0000;
  // Safe view ignores position validity, which is status only
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      safe_view <= 1'b0;
    else
      safe_view <= status.ready && status.torque_off_safe_flag;
endmodule : sso_app_model

// ---- verification/tb_safety_status_outputs.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb_safety_status_outputs;
  import sso_pkg::*;
  logic CLOCK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er, safe_view;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, SAFE_POSITION_VALUE, rd, used_pos;
  logic [13:0] v;
  sso_func_t FUNC_STATE;
  sso_axis_t AXIS_STATE;
  sso_status_t STATUS;
  int fails = 0;
  int samples_checked = 0;
  // Request, active, safe, error, module error -> flag
  logic [5:0] frow [6] = '{6'h39, 6'h18, 6'h28, 6'h30, 6'h3C, 6'h3A};
  // Homed, encoder fault, max monitor, ramp, module error -> max, valid, ramp
  logic [7:0] arow [6] = '{8'hB7, 8'h31, 8'hF5, 8'h82, 8'hB8, 8'hA6};
  sso_status_outputs uut (.CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FUNC_STATE(FUNC_STATE), .AXIS_STATE(AXIS_STATE), .STATUS(STATUS),
    .SAFE_POSITION_VALUE(SAFE_POSITION_VALUE));
  sso_app_model app (.clock(CLOCK), .resetn(RESETN), .status(STATUS),
    .position(SAFE_POSITION_VALUE), .used_pos(used_pos), .safe_view(safe_view));
  initial
  begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  task report_and_stop;
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // Lets inputs reach STATUS and the model before anything is read
  task step;
    repeat (3) @(posedge CLOCK);
  endtask : step
  // One APB transfer; the wait for ready is bounded
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLOCK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    er = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
    if (n >= 20)
    begin
      fails++;
      report_and_stop();
    end
  endtask : apb
  initial
  begin
    {RESETN, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    FUNC_STATE = {{3{14'h3FFF}}, 14'h0000};
    AXIS_STATE = {5'h0B, 32'h1234_5678};
    repeat (20) @(posedge CLOCK);
    `CHK(STATUS, SSO_STATUS_RESET)
    RESETN <= 1'b1;
    step();
    `CHK(STATUS, SSO_STATUS_RESET)
    apb(1'b1, SSO_ADDR_CTRL, 32'h0000_0001);
    step();
    `CHK(STATUS, 18'h3_FFFF)
    `CHK(safe_view, 1'b1)
    apb(1'b0, SSO_ADDR_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0001)
    apb(1'b0, SSO_ADDR_STATUS, 32'h0000_0000);
    `CHK(rd, 32'h0003_FFFF)
    apb(1'b0, SSO_ADDR_POSITION, 32'h0000_0000);
    `CHK(rd, 32'h1234_5678)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    // A write to a hole must be refused and leave activation alone
    apb(1'b1, 12'h010, 32'h0000_0000);
    step();
    `CHK({er, STATUS.ready}, 2'b11)
    for (int i = 0; i < SSO_NUM_FUNC; i++)
      foreach (frow[j])
      begin
        v = 14'h0001 << i;
        FUNC_STATE <= {{14{frow[j][5]}} & v, {14{frow[j][4]}} & v, {14{frow[j][3]}} & v,
          {14{frow[j][2]}} & v};
        AXIS_STATE <= {frow[j][1], 4'hB, 32'h1234_5678};
        step();
        `CHK(STATUS[16:3], 14'(frow[j][0]) << (13 - i))
      end
    // Torque-off held safe, so the safe view must ignore position validity
    FUNC_STATE <= {{3{14'h0001}}, 14'h0000};
    foreach (arow[j])
    begin
      AXIS_STATE <= {arow[j][3], arow[j][7:4], 32'h1234_5678};
      step();
      `CHK(STATUS[2:0], arow[j][2:0])
      `CHK(SAFE_POSITION_VALUE, arow[j][1] ? 32'h1234_5678 : 32'h0000_0000)
      `CHK(used_pos, arow[j][1] ? 32'h1234_5678 : 32'h0000_0000)
      `CHK(safe_view, !arow[j][3])
    end
    FUNC_STATE <= {{3{14'h0000}}, 14'h2A55};
    apb(1'b0, SSO_ADDR_FAULTS, 32'h0000_0000);
    `CHK(rd, 32'h0000_2A55)
    apb(1'b1, SSO_ADDR_CTRL, 32'h0000_0000);
    step();
    `CHK(STATUS, SSO_STATUS_RESET)
    apb(1'b1, SSO_ADDR_CTRL, 32'h0000_0001);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    `CHK(STATUS, SSO_STATUS_RESET)
    RESETN <= 1'b1;
    step();
    `CHK(STATUS, SSO_STATUS_RESET)
    report_and_stop();
  end
endmodule : tb_safety_status_outputs
